//--- verilog/ddrsr_host_ctl.sv
// Host controller end of the DDR burst-2 SRAM link, with request FIFO
`timescale 1ns/100ps
`default_nettype none
`include "ddrsr_params.svh"

module ddrsr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  // Fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // Drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr;
    logic [AW:0]                 rd;
  } ddrsr_fifo_s;

  ddrsr_fifo_s s;
  ddrsr_fifo_s next_s;

  assign o_in_ready  = (s.wr ^ s.rd) != {1'b1, {AW{1'b0}}};
  assign o_out_valid = s.wr != s.rd;
  assign o_out_data  = s.mem[s.rd[AW-1:0]];

  always_comb begin
    next_s = s;
    if (i_in_valid && o_in_ready) begin
      next_s.mem[s.wr[AW-1:0]] = i_in_data;
      next_s.wr = s.wr + 1'b1;
    end
    if (o_out_valid && i_out_ready) begin
      next_s.rd = s.rd + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : ddrsr_fifo

module ddrsr_host_ctl
  import ddrsr_pkg::*;
(
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  // Request port
  input  wire logic         i_req_valid,
  output logic              o_req_ready,
  input  wire logic         i_req_read,
  input  wire ddrsr_addr_t  i_req_addr,
  input  wire ddrsr_data_t  i_req_wdata0,
  input  wire ddrsr_data_t  i_req_wdata1,
  input  wire ddrsr_mask_t  i_req_mask0_n,
  input  wire ddrsr_mask_t  i_req_mask1_n,
  input  wire logic         i_dll_off_n,
  // Read response
  output logic              o_rsp_valid,
  output ddrsr_data_t       o_rsp_data0,
  output ddrsr_data_t       o_rsp_data1,
  // Link pins
  ddrsr_link_if.host        link
);
  localparam logic [2:0] LAST_PH  = 3'(`DDRSR_K_CYCLES - 1);
  localparam logic [2:0] ISSUE_PH = 3'(`DDRSR_ISSUE_PHASE);
  localparam logic [2:0] BEAT2_PH = 3'(`DDRSR_BEAT2_PHASE);
  localparam logic [2:0] HALF_PH  = 3'(`DDRSR_K_CYCLES / 2);

  ddrsr_host_s s;
  ddrsr_host_s next_s;
  ddrsr_req_s  in_req;
  ddrsr_req_s  head;
  logic        head_valid;
  logic        pop;

  always_comb begin
    in_req.rd      = i_req_read;
    in_req.addr    = i_req_addr;
    in_req.wdata0  = i_req_wdata0;
    in_req.wdata1  = i_req_wdata1;
    in_req.mask0_n = i_req_mask0_n;
    in_req.mask1_n = i_req_mask1_n;
  end

  ddrsr_fifo #(
    .WIDTH ($bits(ddrsr_req_s)),
    .DEPTH (`DDRSR_FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_reset     (i_reset),
    .i_in_valid  (i_req_valid),
    .o_in_ready  (o_req_ready),
    .i_in_data   (in_req),
    .o_out_valid (head_valid),
    .i_out_ready (pop),
    .o_out_data  (head)
  );

  // A write waits out the gap so its data never meets read beats
  assign pop = head_valid && (s.phase == ISSUE_PH) // see RULE8
               && (head.rd || s.gap == 2'h0); // see RULE11

  always_comb begin
    next_s = s;
    next_s.phase = (s.phase == LAST_PH) ? 3'h0 : s.phase + 3'h1;
    // Self-made link clocks: true high in the first half period
    next_s.k  = next_s.phase < HALF_PH;
    next_s.kn = next_s.phase >= HALF_PH;
    next_s.dll_off_n = i_dll_off_n;
    next_s.rsp_v = 1'b0;

    // Pins change one i_clk before the true and comp rises that sample them
    if (s.phase == ISSUE_PH) begin
      next_s.dq_oe  = s.wr_stage; // see RULE3
      next_s.b2_due = s.wr_stage;
      next_s.dq_out = s.wd0;
      next_s.wen    = s.wr_stage ? s.wen0 : '0; // see RULE9
      next_s.b2_data = s.wd1;
      next_s.b2_wen  = s.wen1;
      next_s.load     = pop; // see RULE14
      next_s.wr_stage = pop && !head.rd;
      next_s.rd   = head.rd;
      next_s.addr = head.addr;
      next_s.wd0  = head.wdata0;
      next_s.wd1  = head.wdata1;
      next_s.wen0 = ~head.mask0_n; // see RULE15
      next_s.wen1 = ~head.mask1_n;
      if (pop && head.rd) begin
        next_s.gap = `DDRSR_TURN_GAP;
      end else if (s.gap != 2'h0) begin
        next_s.gap = s.gap - 2'h1;
      end
    end
    if (s.phase == BEAT2_PH && s.b2_due) begin
      next_s.dq_out = s.b2_data; // see RULE4
      next_s.wen    = s.b2_wen;
      next_s.b2_due = 1'b0;
    end

    // Returned beats caught on echo edges while valid
    next_s.ec_sy  = {s.ec_sy[0], link.echo_clock_true};
    next_s.ecn_sy = {s.ecn_sy[0], link.echo_clock_comp};
    next_s.vld_sy = {s.vld_sy[0], link.read_data_valid};
    next_s.dq_sy  = {s.dq_sy[0], link.dq};
    next_s.ec_prev  = s.ec_sy[1];
    next_s.ecn_prev = s.ecn_sy[1];
    if (s.ec_sy[1] && !s.ec_prev && s.vld_sy[1]) begin // see RULE10
      next_s.cap0 = s.dq_sy[1];
    end
    if (s.ecn_sy[1] && !s.ecn_prev && s.vld_sy[1]) begin // see RULE7
      next_s.rsp0  = s.cap0;
      next_s.rsp1  = s.dq_sy[1];
      next_s.rsp_v = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign link.in_clock_true     = s.k;
  assign link.in_clock_comp     = s.kn;
  assign link.load_strobe_n     = ~s.load; // see RULE18
  assign link.read_sel          = s.rd;
  assign link.sync_address      = s.addr;
  assign link.byte_write_mask_n = ~s.wen;
  assign link.dll_off_n         = s.dll_off_n;
  assign link.host_dq           = s.dq_out;
  assign link.host_dq_oe        = s.dq_oe; // see RULE11
  assign o_rsp_valid = s.rsp_v;
  assign o_rsp_data0 = s.rsp0;
  assign o_rsp_data1 = s.rsp1;

endmodule : ddrsr_host_ctl

`default_nettype wire

//--- verilog/ddrsr_params.svh
// Constants shared by both ends of the DDR burst-2 SRAM link
`ifndef DDRSR_PARAMS_SVH
`define DDRSR_PARAMS_SVH

`define DDRSR_CLK_NS        4
`define DDRSR_K_PERIOD_NS   32
`define DDRSR_K_CYCLES      (`DDRSR_K_PERIOD_NS / `DDRSR_CLK_NS)
`define DDRSR_ISSUE_PHASE   ((`DDRSR_K_CYCLES * 3) / 4)
`define DDRSR_BEAT2_PHASE   (`DDRSR_K_CYCLES / 4)
`define DDRSR_DQ_W          36
`define DDRSR_ADDR_W        21
`define DDRSR_MASK_W        4
`define DDRSR_BYTE_W        9
`define DDRSR_ENTRY_W       18
`define DDRSR_MEM_AW        22
`define DDRSR_TURN_GAP      2'h2
`define DDRSR_FIFO_DEPTH    4

`endif

//--- verilog/ddrsr_pkg.sv
// Types shared by both ends of the DDR burst-2 SRAM link
`default_nettype none
`include "ddrsr_params.svh"

package ddrsr_pkg;

  typedef logic [`DDRSR_DQ_W-1:0]   ddrsr_data_t;
  typedef logic [`DDRSR_ADDR_W-1:0] ddrsr_addr_t;
  typedef logic [`DDRSR_MASK_W-1:0] ddrsr_mask_t;

  typedef struct packed {
    logic        v;
    logic        rd;
    ddrsr_addr_t addr;
  } ddrsr_cmd_s;

  typedef struct packed {
    logic        rd;
    ddrsr_addr_t addr;
    ddrsr_data_t wdata0;
    ddrsr_data_t wdata1;
    ddrsr_mask_t mask0_n;
    ddrsr_mask_t mask1_n;
  } ddrsr_req_s;

  typedef struct packed {
    logic [1:0]                 k_sy;
    logic [1:0]                 kn_sy;
    logic                       k_prev;
    logic                       kn_prev;
    logic [1:0]                 ld_n_sy;
    logic [1:0]                 rd_sy;
    logic [1:0]                 dll_sy;
    logic [1:0][`DDRSR_ADDR_W-1:0] addr_sy;
    logic [1:0][`DDRSR_MASK_W-1:0] mask_sy;
    logic [1:0][`DDRSR_DQ_W-1:0]   dq_sy;
    ddrsr_cmd_s                 slot1;
    ddrsr_cmd_s                 slot2;
    logic                       b2_wr;
    ddrsr_addr_t                b2_wr_addr;
    logic                       b2_rd;
    ddrsr_addr_t                b2_rd_addr;
    ddrsr_data_t                dq_out;
    logic                       dq_oe;
  } ddrsr_dev_s;

  typedef struct packed {
    logic [2:0]                 phase;
    logic                       k;
    logic                       kn;
    logic                       load;
    logic                       rd;
    ddrsr_addr_t                addr;
    ddrsr_mask_t                wen;
    ddrsr_data_t                dq_out;
    logic                       dq_oe;
    logic                       wr_stage;
    ddrsr_data_t                wd0;
    ddrsr_data_t                wd1;
    ddrsr_mask_t                wen0;
    ddrsr_mask_t                wen1;
    logic                       b2_due;
    ddrsr_data_t                b2_data;
    ddrsr_mask_t                b2_wen;
    logic [1:0]                 gap;
    logic                       dll_off_n;
    logic [1:0]                 ec_sy;
    logic [1:0]                 ecn_sy;
    logic [1:0]                 vld_sy;
    logic [1:0][`DDRSR_DQ_W-1:0] dq_sy;
    logic                       ec_prev;
    logic                       ecn_prev;
    ddrsr_data_t                cap0;
    logic                       rsp_v;
    ddrsr_data_t                rsp0;
    ddrsr_data_t                rsp1;
  } ddrsr_host_s;

endpackage : ddrsr_pkg

`default_nettype wire

//--- verilog/ddrsr_link_if.sv
// Pin-level link between the host controller and the SRAM
`timescale 1ns/100ps
`default_nettype none
`include "ddrsr_params.svh"

interface ddrsr_link_if;
  logic                    in_clock_true;
  logic                    in_clock_comp;
  logic                    load_strobe_n;
  logic                    read_sel;
  logic [`DDRSR_ADDR_W-1:0] sync_address;
  logic [`DDRSR_MASK_W-1:0] byte_write_mask_n;
  logic                    dll_off_n;
  logic [`DDRSR_DQ_W-1:0]   host_dq;
  logic                    host_dq_oe;
  logic [`DDRSR_DQ_W-1:0]   dev_dq;
  logic                    dev_dq_oe;
  logic [`DDRSR_DQ_W-1:0]   dq;
  logic                    echo_clock_true;
  logic                    echo_clock_comp;
  logic                    read_data_valid;

  // Shared wire level worked out from the two enables; rests high when
  // released, as through pull-ups
  assign dq = dev_dq_oe ? dev_dq : (host_dq_oe ? host_dq : '1);

  modport dev (
    input  in_clock_true, in_clock_comp, load_strobe_n, read_sel,
    input  sync_address, byte_write_mask_n, dll_off_n, dq,
    output dev_dq, dev_dq_oe, echo_clock_true, echo_clock_comp,
    output read_data_valid
  );

  modport host (
    output in_clock_true, in_clock_comp, load_strobe_n, read_sel,
    output sync_address, byte_write_mask_n, dll_off_n,
    output host_dq, host_dq_oe,
    input  dq, echo_clock_true, echo_clock_comp, read_data_valid
  );
endinterface : ddrsr_link_if

`default_nettype wire

//--- verilog/ddrsr_sram_dev.sv
// SRAM end of the DDR burst-2 common-I/O link, with its own array
`timescale 1ns/100ps
`default_nettype none
`include "ddrsr_params.svh"

// Behaviour
// RULE1: Address, command, beat-1 mask/data on true rise
// RULE2: Beat-2 mask/data in, beat-2 out on comp rise
// RULE3: First write beat one cycle after command
// RULE4: Second write beat at following comp rise
// RULE5: First read beat from third true rise
// RULE6: Second read beat from third comp rise
// RULE7: Every access moves exactly two beats
// RULE8: Host issues one address per true cycle
// RULE9: Masks follow their beat; only enabled bytes written
// RULE10: Echo clocks edge-aligned with read data
// RULE11: One shared data bus; host releases on reads
// RULE12: x36 by 2M or x18 by 4M organisation
// RULE13: True rise starts access; array self-timed
// RULE14: Load low: select high reads, low writes
// RULE15: Mask low writes byte, high keeps it
// RULE16: Valid output high while read beats driven
// RULE17: DLL off gives one cycle read latency
// RULE18: Load high deselects; inputs ignored
module ddrsr_sram_dev
  import ddrsr_pkg::*;
#(
  parameter bit X36 = 1'b1
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset,
  // Link pins
  ddrsr_link_if.dev link
);

  ////////////////////////////////////////////////////////////////////////
  // Array and helpers

  // x36 word = two 18-bit entries; x18 word = one entry
  logic [`DDRSR_ENTRY_W-1:0] mem [0:(1 << `DDRSR_MEM_AW)-1];
  // Not cleared by i_reset: data survives a reset.
  // Too large for the state struct, so it has
  // a process of its own.

  ddrsr_dev_s  s;
  ddrsr_dev_s  next_s;
  ddrsr_cmd_s  cmd;
  ddrsr_cmd_s  src;
  logic        k_rise;
  logic        kn_rise;
  logic        we;
  logic        wbeat;
  ddrsr_addr_t waddr;
  ddrsr_mask_t wen;
  ddrsr_data_t wdata;

  // Entry index for a burst beat and word half
  // x36 leaves the top address bit unused
  function automatic logic [`DDRSR_MEM_AW-1:0] ent(
    input ddrsr_addr_t a,
    input logic        beat,
    input logic        half
  );
    if (X36) begin // see RULE12
      return {a[`DDRSR_ADDR_W-2:0], beat, half};
    end
    return {a, beat};
  endfunction : ent

  // Narrow parts read 18 bits, upper half zero
  function automatic ddrsr_data_t rd_word(
    input ddrsr_addr_t a,
    input logic        beat
  );
    if (X36) begin // see RULE12
      return {mem[ent(a, beat, 1'b1)], mem[ent(a, beat, 1'b0)]};
    end
    return {{(`DDRSR_DQ_W-`DDRSR_ENTRY_W){1'b0}}, mem[ent(a, beat, 1'b0)]};
  endfunction : rd_word

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    next_s = s;
    we     = 1'b0;
    wbeat  = 1'b0;
    waddr  = '0;
    wen    = '0;
    wdata  = '0;
    src    = '0;

    // All pins pass two flops; both link clocks are sampled like data
    // Pins must hold for a few i_clk around link edges
    next_s.k_sy    = {s.k_sy[0], link.in_clock_true};
    next_s.kn_sy   = {s.kn_sy[0], link.in_clock_comp};
    next_s.ld_n_sy = {s.ld_n_sy[0], link.load_strobe_n};
    next_s.rd_sy   = {s.rd_sy[0], link.read_sel};
    next_s.dll_sy  = {s.dll_sy[0], link.dll_off_n};
    next_s.addr_sy = {s.addr_sy[0], link.sync_address};
    next_s.mask_sy = {s.mask_sy[0], link.byte_write_mask_n};
    next_s.dq_sy   = {s.dq_sy[0], link.dq};
    next_s.k_prev  = s.k_sy[1];
    next_s.kn_prev = s.kn_sy[1];

    // Edges show three i_clk after the pin moves
    k_rise  = s.k_sy[1] & ~s.k_prev;
    kn_rise = s.kn_sy[1] & ~s.kn_prev;

    // Select and address ride along when deselected;
    // only the valid bit starts anything
    // Deselect leaves the slot empty
    cmd.v    = ~s.ld_n_sy[1]; // see RULE18
    cmd.rd   = s.rd_sy[1]; // see RULE14
    cmd.addr = s.addr_sy[1];

    if (k_rise) begin
      // Command sampled here starts the access
      next_s.slot1 = cmd; // see RULE1
      next_s.slot2 = s.slot1; // see RULE13

      // Write from the previous cycle takes its first beat now
      // Beat two follows on the comp edge
      if (s.slot1.v && !s.slot1.rd) begin // see RULE3
        we     = 1'b1;
        wbeat  = 1'b0;
        waddr  = s.slot1.addr;
        wen    = ~s.mask_sy[1]; // see RULE15
        wdata  = s.dq_sy[1]; // see RULE1
        next_s.b2_wr      = 1'b1; // see RULE7
        next_s.b2_wr_addr = s.slot1.addr;
      end else begin
        next_s.b2_wr = 1'b0;
      end

      // DLL bypass shortens the read pipe by one stage
      // Not drained on a mode change: switch only when
      // idle, or a read may answer twice or not at all
      src = s.dll_sy[1] ? s.slot2 : s.slot1; // see RULE17
      if (src.v && src.rd) begin
        next_s.dq_out     = rd_word(src.addr, 1'b0); // see RULE5
        next_s.dq_oe      = 1'b1; // see RULE11
        next_s.b2_rd      = 1'b1; // see RULE7
        next_s.b2_rd_addr = src.addr;
      end else begin
        next_s.dq_oe = 1'b0;
        next_s.b2_rd = 1'b0;
      end
    end

    // Second half of the burst
    if (kn_rise) begin
      if (s.b2_wr) begin // see RULE4
        we    = 1'b1;
        wbeat = 1'b1;
        waddr = s.b2_wr_addr;
        wen   = ~s.mask_sy[1]; // see RULE9
        wdata = s.dq_sy[1]; // see RULE2
        next_s.b2_wr = 1'b0;
      end
      if (s.b2_rd) begin
        next_s.dq_out = rd_word(s.b2_rd_addr, 1'b1); // see RULE6
        next_s.b2_rd  = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State and array registers

  // Reset empties the pipe and sync chains together
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Only bytes whose mask was low on this beat change
  always_ff @(posedge i_clk) begin
    if (we) begin
      for (int b = 0; b < `DDRSR_MASK_W; b++) begin
        // Narrow parts have two lanes; upper masks ignored
        if (wen[b] && (X36 || b < 2)) begin // see RULE9
          mem[ent(waddr, wbeat, 1'((b / 2) % 2))]
             [(b % 2) * `DDRSR_BYTE_W +: `DDRSR_BYTE_W]
            <= wdata[b * `DDRSR_BYTE_W +: `DDRSR_BYTE_W];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin outputs

  // Echo clocks come from the same flops that time the data launch
  // They run on while the bus is released: the host
  // must qualify them with the valid flag
  assign link.echo_clock_true = s.k_prev; // see RULE10
  assign link.echo_clock_comp = s.kn_prev; // see RULE10
  assign link.dev_dq          = s.dq_out;
  assign link.dev_dq_oe       = s.dq_oe; // see RULE11
  assign link.read_data_valid = s.dq_oe; // see RULE16

endmodule : ddrsr_sram_dev

`default_nettype wire

//--- test/ddrsr_link_asserts.sv
// Link-level checks between the host controller and the SRAM end
`timescale 1ns/100ps
`default_nettype none

module ddrsr_link_asserts (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset,
  // Host-driven link pins
  input  wire logic in_clock_true,
  input  wire logic load_strobe_n,
  input  wire logic read_sel,
  input  wire logic dll_off_n,
  input  wire logic host_dq_oe,
  // Device-driven link pins
  input  wire logic dev_dq_oe,
  input  wire logic echo_clock_true,
  input  wire logic echo_clock_comp,
  input  wire logic read_data_valid
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  ////////////////////////////////////////////////////////////////////////////
  // Read timing against the command edge
  // Windows are 7 cycles wide: the next slot is a full 8-cycle period away
  read_lat_a: assert property (($rose(in_clock_true) && !load_strobe_n
    && read_sel && dll_off_n) |-> ##[16:22]
    ($rose(echo_clock_true) && dev_dq_oe))
    else $error("first read beat missing two periods after command");
  short_lat_a: assert property (($rose(in_clock_true) && !load_strobe_n
    && read_sel && !dll_off_n) |-> ##[8:14]
    ($rose(echo_clock_true) && dev_dq_oe))
    else $error("first read beat missing one period after command");
  no_access_a: assert property (($rose(in_clock_true) && dll_off_n
    && (load_strobe_n || !read_sel)) |->
    ##16 (!($rose(echo_clock_true) && dev_dq_oe))[*7])
    else $error("read beat driven without a read command");
  beat_two_a: assert property ($rose(dev_dq_oe) |->
    ##4 ($rose(echo_clock_comp) && dev_dq_oe))
    else $error("second read beat not on comp echo rise");
  two_beats_a: assert property ($rose(dev_dq_oe) |-> dev_dq_oe[*8])
    else $error("read drive shorter than one period");

  ////////////////////////////////////////////////////////////////////////////
  // Echo clocks, valid flag and bus ownership
  drive_edge_a: assert property ($rose(dev_dq_oe) |-> $rose(echo_clock_true))
    else $error("read drive starts off the echo edge");
  drop_edge_a: assert property ($fell(dev_dq_oe) |-> $rose(echo_clock_true))
    else $error("read drive ends off the echo edge");
  valid_oe_a: assert property (read_data_valid == dev_dq_oe)
    else $error("valid flag differs from read drive");
  bus_owner_a: assert property (!(host_dq_oe && dev_dq_oe))
    else $error("both ends drive the data bus");

  ////////////////////////////////////////////////////////////////////////////
  // Host side of the write and command timing
  write_beats_a: assert property (($rose(in_clock_true)
    && !load_strobe_n && !read_sel) |-> ##8 host_dq_oe[*5])
    else $error("write beats not one period after command");
  cmd_setup_a: assert property ($fell(load_strobe_n) |->
    ##1 $rose(in_clock_true))
    else $error("command not placed before a true clock rise");

  rd_cover: cover property ($rose(dev_dq_oe) && dll_off_n);
  rd_short_cover: cover property ($rose(dev_dq_oe) && !dll_off_n);
  wr_cover: cover property ($rose(host_dq_oe));
endmodule : ddrsr_link_asserts

`default_nettype wire

//--- test/ddrsr_tb.sv
// Self-checking bench: host controller and SRAM end joined by the link
`timescale 1ns/100ps
`default_nettype none

module ddrsr_tb import ddrsr_pkg::*;;
  logic        i_clk;
  logic        i_reset;
  logic        i_req_valid;
  logic        i_dll_off_n;
  logic        o_req_ready;
  logic        o_rsp_valid;
  ddrsr_data_t o_rsp_data0;
  ddrsr_data_t o_rsp_data1;
  ddrsr_req_s  req;
  ddrsr_data_t mem0 [ddrsr_addr_t];
  ddrsr_data_t mem1 [ddrsr_addr_t];
  ddrsr_data_t exp0 [$];
  ddrsr_data_t exp1 [$];
  int          n_errors;
  int          checks_done;
  int          cycles;
  logic        saw_full;
  logic        vld_q;

  // Table rows: writes first, reads only once their writes are well past
  ddrsr_req_s rows [7] = '{
    '{1'b0, 21'h000010, 36'h123456789, 36'h0FEDCBA98, 4'h0, 4'h0},
    '{1'b0, 21'h0FFFFF, 36'h111111111, 36'h222222222, 4'h0, 4'h0},
    '{1'b0, 21'h000000, 36'hFFFFFFFFF, 36'h000000000, 4'h0, 4'h0},
    '{1'b0, 21'h000010, 36'h333333333, 36'h444444444, 4'h5, 4'hA},
    '{1'b1, 21'h0FFFFF, '0, '0, 4'hF, 4'hF},
    '{1'b1, 21'h000000, '0, '0, 4'hF, 4'hF},
    '{1'b1, 21'h000010, '0, '0, 4'hF, 4'hF}};

  ddrsr_link_if ddrsr_link_if_i ();

  ddrsr_sram_dev #(.X36(1'b1)) ddrsr_sram_dev_i (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .link    (ddrsr_link_if_i.dev)
  );

  ddrsr_host_ctl ddrsr_host_ctl_i (
    .i_clk         (i_clk),
    .i_reset       (i_reset),
    .i_req_valid   (i_req_valid),
    .o_req_ready   (o_req_ready),
    .i_req_read    (req.rd),
    .i_req_addr    (req.addr),
    .i_req_wdata0  (req.wdata0),
    .i_req_wdata1  (req.wdata1),
    .i_req_mask0_n (req.mask0_n),
    .i_req_mask1_n (req.mask1_n),
    .i_dll_off_n   (i_dll_off_n),
    .o_rsp_valid   (o_rsp_valid),
    .o_rsp_data0   (o_rsp_data0),
    .o_rsp_data1   (o_rsp_data1),
    .link          (ddrsr_link_if_i.host)
  );

  // Narrow part on a bus of its own, fed from the same host pins
  ddrsr_link_if x18_if_i ();
  assign x18_if_i.in_clock_true     = ddrsr_link_if_i.in_clock_true;
  assign x18_if_i.in_clock_comp     = ddrsr_link_if_i.in_clock_comp;
  assign x18_if_i.load_strobe_n     = ddrsr_link_if_i.load_strobe_n;
  assign x18_if_i.read_sel          = ddrsr_link_if_i.read_sel;
  assign x18_if_i.sync_address      = ddrsr_link_if_i.sync_address;
  assign x18_if_i.byte_write_mask_n = ddrsr_link_if_i.byte_write_mask_n;
  assign x18_if_i.dll_off_n         = ddrsr_link_if_i.dll_off_n;
  assign x18_if_i.host_dq           = ddrsr_link_if_i.host_dq;
  assign x18_if_i.host_dq_oe        = ddrsr_link_if_i.host_dq_oe;

  ddrsr_sram_dev #(.X36(1'b0)) ddrsr_sram_dev_x18_i (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .link    (x18_if_i.dev)
  );

  ddrsr_link_asserts ddrsr_link_asserts_i (
    .i_clk           (i_clk),
    .i_reset         (i_reset),
    .in_clock_true   (ddrsr_link_if_i.in_clock_true),
    .load_strobe_n   (ddrsr_link_if_i.load_strobe_n),
    .read_sel        (ddrsr_link_if_i.read_sel),
    .dll_off_n       (ddrsr_link_if_i.dll_off_n),
    .host_dq_oe      (ddrsr_link_if_i.host_dq_oe),
    .dev_dq_oe       (ddrsr_link_if_i.dev_dq_oe),
    .echo_clock_true (ddrsr_link_if_i.echo_clock_true),
    .echo_clock_comp (ddrsr_link_if_i.echo_clock_comp),
    .read_data_valid (ddrsr_link_if_i.read_data_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run();
    if (n_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  // Bytes are 9 bits; a low mask bit lets its byte through
  function automatic ddrsr_data_t merge(ddrsr_data_t old, ddrsr_data_t nw,
                                        ddrsr_mask_t mn);
    for (int b = 0; b < 4; b++)
      if (mn[b] === 1'b0) old[9*b +: 9] = nw[9*b +: 9];
    return old;
  endfunction : merge

  // Leaves valid high so back-to-back calls never pulse it
  task automatic send(input ddrsr_req_s r);
    int n;
    n = 0;
    req = r;
    i_req_valid = 1'b1;
    if (r.rd) begin
      exp0.push_back(mem0[r.addr]);
      exp1.push_back(mem1[r.addr]);
    end else begin
      mem0[r.addr] = merge(mem0.exists(r.addr) ? mem0[r.addr] : 'x,
                           r.wdata0, r.mask0_n);
      mem1[r.addr] = merge(mem1.exists(r.addr) ? mem1[r.addr] : 'x,
                           r.wdata1, r.mask1_n);
    end
    while (o_req_ready !== 1'b1 && n < 200) begin
      saw_full = 1'b1;
      n++;
      @(negedge i_clk);
    end
    @(negedge i_clk);
  endtask : send

  task automatic drain();
    int n;
    i_req_valid = 1'b0;
    for (n = 0; n < 400 && exp0.size() != 0; n++) @(negedge i_clk);
    check(36'(exp0.size()), 36'h0);
  endtask : drain

  // Responses and the first read beat on the shared wire
  always @(negedge i_clk) begin
    vld_q <= ddrsr_link_if_i.read_data_valid;
    if (ddrsr_link_if_i.read_data_valid === 1'b1 && vld_q === 1'b0) begin
      check(ddrsr_link_if_i.dq, exp0[0]);
      check(x18_if_i.dq, {18'h0, exp0[0][17:0]});
    end
    if (o_rsp_valid === 1'b1) begin
      if (exp0.size() == 0) check(36'h1, 36'h0);
      else begin
        check(o_rsp_data0, exp0.pop_front());
        check(o_rsp_data1, exp1.pop_front());
      end
    end
  end

  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_errors++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_reset = 1'b1;
    i_req_valid = 1'b0;
    i_dll_off_n = 1'b1;
    req = '0;
    saw_full = 1'b0;
    vld_q = 1'b0;
    n_errors = 0;
    checks_done = 0;
    cycles = 0;
    repeat (8) @(negedge i_clk);
    i_reset = 1'b0;
    foreach (rows[i]) send(rows[i]);
    drain();
    // Queue overrun: the fill side must refuse, then reads stream out
    for (int k = 0; k < 6; k++)
      send('{1'b0, 21'h20 + 21'(k), {4{9'h0A5 + 9'(k)}}, {4{9'(k)}},
             4'h0, 4'h0});
    for (int k = 0; k < 6; k++)
      send('{1'b1, 21'h20 + 21'(k), '0, '0, 4'hF, 4'hF});
    drain();
    check(36'(saw_full), 36'h1);
    // Turnaround: read, then write and read back the same place
    send('{1'b1, 21'h0FFFFF, '0, '0, 4'hF, 4'hF});
    send('{1'b0, 21'h0FFFFF, 36'h5A5A5A5A5, 36'hA5A5A5A5A, 4'h0, 4'h6});
    send('{1'b1, 21'h000000, '0, '0, 4'hF, 4'hF});
    send('{1'b1, 21'h0FFFFF, '0, '0, 4'hF, 4'hF});
    drain();
    // One-period latency with the loop bypassed
    i_dll_off_n = 1'b0;
    repeat (40) @(negedge i_clk);
    send('{1'b1, 21'h000010, '0, '0, 4'hF, 4'hF});
    send('{1'b1, 21'h000021, '0, '0, 4'hF, 4'hF});
    drain();
    i_dll_off_n = 1'b1;
    repeat (40) @(negedge i_clk);
    // Second reset while idle
    i_reset = 1'b1;
    repeat (8) @(negedge i_clk);
    check(36'(ddrsr_link_if_i.load_strobe_n), 36'h1);
    check(36'(ddrsr_link_if_i.byte_write_mask_n), 36'hF);
    check(36'(o_rsp_valid), 36'h0);
    i_reset = 1'b0;
    send('{1'b0, 21'h000040, 36'h0C0FFEE00, 36'h00BADF00D, 4'h0, 4'h0});
    send('{1'b1, 21'h000000, '0, '0, 4'hF, 4'hF});
    send('{1'b1, 21'h000040, '0, '0, 4'hF, 4'hF});
    drain();
    complete_run();
  end
endmodule : ddrsr_tb

`default_nettype wire
